// ---- sim/core_model.sv ----
// processor core model: takes a request, services it, returns
`timescale 1ns/1ns
module core_model (
	input  logic               ref_clk,     // clock
	input  logic               reset_n,     // reset, low
	input  logic               coreIrqReq,  // request
	input  irq_flags_pkg::pc_t resumePc,    // popped address
	input  logic               resumeValid, // pop strobe
	input  logic [3:0]         serviceLen,  // cycles in routine
	output logic               irqTake,     // take strobe
	output irq_flags_pkg::pc_t returnPc,    // pushed address
	output logic               irqReturn,   // return strobe
	output irq_flags_pkg::pc_t lastPc,      // last popped address
	output int                 takenCount   // services done
);
	import irq_flags_pkg::*;
	pc_t pcNext; // address pushed by the next take
	// one process owns every output; design outputs are read as they stood before the edge
	initial
	begin
		irqTake    = 1'b0;
		irqReturn  = 1'b0;
		returnPc   = '0;
		lastPc     = '0;
		takenCount = 0;
		pcNext     = 13'h0a5;
		forever
		begin
			@(posedge ref_clk);
			if (reset_n && coreIrqReq)
			begin
				irqTake  <= 1'b1;
				returnPc <= pcNext;
				@(posedge ref_clk);
				irqTake  <= 1'b0;
				returnPc <= ~pcNext; // stale address is not held
				repeat (serviceLen) @(posedge ref_clk);
				irqReturn <= 1'b1;
				@(posedge ref_clk);
				irqReturn <= 1'b0;
				// resume strobe is launched at the return edge, so look one edge later
				@(posedge ref_clk);
				if (resumeValid)
					lastPc = resumePc;
				takenCount = takenCount + 1;
				pcNext = pcNext + 13'h001;
			end
		end
	end
endmodule : core_model

// ---- sim/periph_irq_flags_properties.sv ----
// checker of the peripheral interrupt flag block, bound to its top
`timescale 1ns/1ns
module periph_irq_flags_properties (
	input logic                 ref_clk,           // clock
	input logic                 reset_n,           // reset, low
	input irq_flags_pkg::addr_t busAddr,           // address
	input irq_flags_pkg::byte_t busWrData,         // write data
	input logic                 busWr,             // write strobe
	input logic                 busRd,             // read strobe
	input irq_flags_pkg::byte_t busRdData,         // read data
	input logic                 adcDone,           // conversion done
	input logic                 timer1Rollover,    // timer 1 roll-over
	input logic                 inputLow,          // supply low
	input irq_flags_pkg::byte_t periphEnable1,     // enables 1
	input irq_flags_pkg::byte_t periphEnable2,     // enables 2
	input logic                 globalIrqGate,     // global gate
	input logic                 peripheralIrqGate, // peripheral gate
	input logic                 irqTake,           // take strobe
	input irq_flags_pkg::pc_t   returnPc,          // pushed address
	input logic                 irqReturn,         // return strobe
	input logic                 coreIrqReq,        // core request
	input irq_flags_pkg::pc_t   resumePc,          // popped address
	input logic                 resumeValid,       // pop strobe
	input logic                 intOut             // block interrupt
);
	import irq_flags_pkg::*;
	pc_t pcSaved_q; // last pushed address
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// one level deep only: the bench never nests interrupts
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			pcSaved_q <= '0;
		else if (irqTake)
			pcSaved_q <= returnPc;
	end
	// ****************************************
	// properties
	// ****************************************
	property p_gate;
		coreIrqReq |-> $past(peripheralIrqGate && globalIrqGate);
	endproperty
	a_gate: assert property (p_gate) else $error("request without gates");
	property p_enable;
		coreIrqReq |-> $past(periphEnable1 | periphEnable2) != 8'h00;
	endproperty
	a_enable: assert property (p_enable) else $error("request without enable");
	property p_rsvd1;
		$past(busRd) && $past(busAddr) == 9'h000 |-> (busRdData & 8'h8c) == 8'h00;
	endproperty
	a_rsvd1: assert property (p_rsvd1) else $error("flags1 spare bit set");
	property p_rsvd2;
		$past(busRd) && $past(busAddr) == 9'h001 |-> (busRdData & 8'h4d) == 8'h00;
	endproperty
	a_rsvd2: assert property (p_rsvd2) else $error("flags2 spare bit set");
	property p_t1set;
		timer1Rollover ##1 (busRd && busAddr == 9'h000) |=> busRdData[0];
	endproperty
	a_t1set: assert property (p_t1set) else $error("roll-over flag missing");
	property p_setwins;
		adcDone && busWr && busAddr == 9'h000 && !busWrData[6] ##1 (busRd && busAddr == 9'h000) |=> busRdData[6];
	endproperty
	a_setwins: assert property (p_setwins) else $error("event lost to clear");
	property p_vinlow;
		inputLow ##1 (busRd && busAddr == 9'h001) |=> busRdData[1];
	endproperty
	a_vinlow: assert property (p_vinlow) else $error("supply low flag clear");
	property p_take;
		irqTake |=> !coreIrqReq [*2];
	endproperty
	a_take: assert property (p_take) else $error("request during service");
	property p_resume;
		resumeValid |-> $past(irqReturn) && resumePc == pcSaved_q;
	endproperty
	a_resume: assert property (p_resume) else $error("wrong resume address");
	property p_reset;
		$rose(reset_n) |-> busRdData == 8'h00 && !coreIrqReq && !resumeValid && !intOut;
	endproperty
	a_reset: assert property (p_reset) else $error("output busy after reset");
	c_take: cover property (irqTake);
	c_resume: cover property (resumeValid);
	c_int: cover property (intOut);
endmodule : periph_irq_flags_properties

bind periph_irq_flags periph_irq_flags_properties periph_irq_flags_properties_inst (
	.ref_clk(ref_clk), .reset_n(reset_n), .busAddr(busAddr), .busWrData(busWrData),
	.busWr(busWr), .busRd(busRd), .busRdData(busRdData), .adcDone(adcDone),
	.timer1Rollover(timer1Rollover), .inputLow(inputLow), .periphEnable1(periphEnable1),
	.periphEnable2(periphEnable2), .globalIrqGate(globalIrqGate), .peripheralIrqGate(peripheralIrqGate),
	.irqTake(irqTake), .returnPc(returnPc), .irqReturn(irqReturn), .coreIrqReq(coreIrqReq),
	.resumePc(resumePc), .resumeValid(resumeValid), .intOut(intOut));

// ---- sim/periph_irq_flags_tb_top.sv ----
// self-checking bench of the peripheral interrupt flag block
`timescale 1ns/1ns
`define CHK(N, E, S) \
	begin \
		checked++; \
		if ((S) !== (E)) \
		begin \
			errCount++; \
			$display("Error %s expected %h seen %h", N, E, S); \
		end \
	end
module periph_irq_flags_tb_top;
	import irq_flags_pkg::*;
	logic  ref_clk, reset_n, busWr, busRd, inputLow, globalIrqGate, peripheralIrqGate;
	logic  irqTake, irqReturn, coreIrqReq, resumeValid, intOut;
	logic  [3:0] serviceLen;
	logic  [7:0] evt; // undervolt, overcurrent, overvolt, adc, collision, serial, match, rollover
	addr_t busAddr;
	byte_t busWrData, busRdData, periphEnable1, periphEnable2;
	pc_t   returnPc, resumePc, lastPc;
	int    takenCount, errCount, checked;
	byte_t evMask [8] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h40, 8'h10, 8'h20, 8'h80};

	periph_irq_flags periph_irq_flags_inst (.ref_clk(ref_clk), .reset_n(reset_n),
		.busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData(busRdData),
		.adcDone(evt[4]), .serialEvent(evt[2]), .serialCollision(evt[3]), .timer2Match(evt[1]),
		.timer1Rollover(evt[0]), .outUndervolt(evt[7]), .outOvercurrent(evt[6]), .outOvervolt(evt[5]),
		.inputLow(inputLow), .periphEnable1(periphEnable1), .periphEnable2(periphEnable2),
		.globalIrqGate(globalIrqGate), .peripheralIrqGate(peripheralIrqGate), .irqTake(irqTake),
		.returnPc(returnPc), .irqReturn(irqReturn), .coreIrqReq(coreIrqReq), .resumePc(resumePc),
		.resumeValid(resumeValid), .intOut(intOut));
	core_model core_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .coreIrqReq(coreIrqReq),
		.resumePc(resumePc), .resumeValid(resumeValid), .serviceLen(serviceLen), .irqTake(irqTake),
		.returnPc(returnPc), .irqReturn(irqReturn), .lastPc(lastPc), .takenCount(takenCount));

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic wr(input addr_t a, input byte_t d);
		@(posedge ref_clk);
		busWr <= 1'b1;
		busAddr <= a;
		busWrData <= d;
		@(posedge ref_clk);
		busWr <= 1'b0;
	endtask : wr
	// read strobe also ends any pending write or event pulse
	task automatic rc(input addr_t a, input byte_t e);
		byte_t v;
		@(posedge ref_clk);
		busWr <= 1'b0;
		evt <= 8'h00;
		busRd <= 1'b1;
		busAddr <= a;
		@(posedge ref_clk);
		busRd <= 1'b0;
		#1;
		v = busRdData;
		`CHK($sformatf("reg %h", a), e, v)
	endtask : rc
	task automatic pulse_read(input byte_t m, input addr_t a, input byte_t e);
		@(posedge ref_clk);
		evt <= m;
		rc(a, e);
	endtask : pulse_read
	task automatic see_take(input int n, input logic e);
		logic s;
		s = 1'b0;
		repeat (n)
		begin
			@(negedge ref_clk);
			s = s | irqTake;
		end
		`CHK("take", e, s)
	endtask : see_take
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, errCount);
		if (errCount == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_events;
		for (int i = 0; i < 8; i++)
		begin
			pulse_read(8'h01 << i, {8'h00, i > 4}, evMask[i]);
			wr({8'h00, i > 4}, 8'h00);
		end
		rc(9'h000, 8'h00);
		rc(9'h001, 8'h00);
		wr(9'h000, 8'hff);
		rc(9'h000, 8'h73);
		wr(9'h001, 8'hff);
		rc(9'h001, 8'hb2);
		wr(9'h001, 8'h00);
		wr(9'h002, 8'h0f);
		rc(9'h002, 8'h00);
		rc(9'h085, 8'h00);
	endtask : test_events
	// supply low is a level, so a clear only sticks once it is gone
	task automatic test_vin;
		@(posedge ref_clk);
		inputLow <= 1'b1;
		rc(9'h001, 8'h02);
		wr(9'h001, 8'h00);
		rc(9'h001, 8'h02);
		@(posedge ref_clk);
		inputLow <= 1'b0;
		wr(9'h001, 8'h00);
		rc(9'h001, 8'h00);
	endtask : test_vin
	task automatic test_setwins;
		@(posedge ref_clk);
		evt <= 8'h10;
		busWr <= 1'b1;
		busAddr <= 9'h000;
		busWrData <= 8'h00;
		rc(9'h000, 8'h40);
		wr(9'h000, 8'h00);
	endtask : test_setwins
	task automatic test_request;
		wr(9'h000, 8'h00);
		@(posedge ref_clk);
		globalIrqGate <= 1'b1;
		peripheralIrqGate <= 1'b1;
		periphEnable1 <= 8'h02;
		periphEnable2 <= 8'hb2;
		pulse_read(8'h01, 9'h000, 8'h01);
		see_take(12, 1'b0);
		@(posedge ref_clk);
		peripheralIrqGate <= 1'b0;
		periphEnable1 <= 8'h01;
		see_take(12, 1'b0);
		@(posedge ref_clk);
		peripheralIrqGate <= 1'b1;
		see_take(4, 1'b1);
		wr(9'h000, 8'h00);
		rc(9'h004, 8'h01);
		rc(9'h002, 8'h01);
		for (int i = 0; i < 20 && takenCount == 0; i++)
			@(negedge ref_clk);
		`CHK("resume address", 13'h0a5, lastPc)
		rc(9'h004, 8'h00);
		@(posedge ref_clk);
		globalIrqGate <= 1'b0;
	endtask : test_request
	// fault status raises the block line only while masked in
	task automatic test_intout;
		wr(9'h002, 8'h0f);
		pulse_read(8'h40, 9'h002, 8'h08);
		`CHK("intOut", 1'b0, intOut)
		wr(9'h003, 8'h08);
		rc(9'h003, 8'h08);
		`CHK("intOut", 1'b1, intOut)
		wr(9'h002, 8'h08);
		rc(9'h002, 8'h00);
		`CHK("intOut", 1'b0, intOut)
		wr(9'h0f5, 8'h5a);
		rc(9'h1f5, 8'h5a);
		wr(9'h07f, 8'hc3);
		rc(9'h17f, 8'hc3);
		wr(9'h000, 8'h73);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		rc(9'h000, 8'h00);
		rc(9'h003, 8'h00);
	endtask : test_intout

	// ****************************************
	// clock, sequence and watchdog
	// ****************************************
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial
	begin
		{reset_n, busWr, busRd, inputLow, globalIrqGate, peripheralIrqGate} = '0;
		{busAddr, busWrData, periphEnable1, periphEnable2, evt} = '0;
		serviceLen = 4'hc;
		errCount = 0;
		checked = 0;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		rc(9'h000, 8'h00);
		rc(9'h001, 8'h00);
		test_events();
		test_vin();
		test_setwins();
		test_request();
		test_intout();
		end_sim();
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		errCount++;
		end_sim();
	end
endmodule : periph_irq_flags_tb_top

// ---- src/flag_bank.sv ----
// one peripheral interrupt flag register with set-wins update
`timescale 1ns/1ns
`include "irq_flags_map.svh"
module flag_bank #(
	parameter irq_flags_pkg::byte_t IMPL = 8'hff // implemented bit positions
) (
	input wire logic ref_clk, // system clock
	input wire logic reset_n, // asynchronous reset, active low
	flag_if.bank     port     // set, write and flag value
);
	import irq_flags_pkg::*;

	byte_t flags_q;
	byte_t flags_d;

	// software value first, then hardware sets on top so an event is never lost
	always_comb
	begin
		flags_d = flags_q;
		if (port.wrEn)
		begin
			flags_d = port.wrData;
		end
		flags_d = (flags_d | port.setVec) & IMPL;
	end

	// every implemented flag starts clear
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			flags_q <= `RST_FLAGS;
		else
			flags_q <= flags_d;
	end

	assign port.flags = flags_q;
endmodule : flag_bank

// ---- src/flag_if.sv ----
// interface between the top and one flag register
`timescale 1ns/1ns
interface flag_if;
	irq_flags_pkg::byte_t setVec;  // hardware set requests, one bit per flag
	logic                 wrEn;    // software write of the whole register
	irq_flags_pkg::byte_t wrData;  // value written by software
	irq_flags_pkg::byte_t flags;   // current flag value, unimplemented bits zero

	modport bank (input setVec, input wrEn, input wrData, output flags);
	modport user (output setVec, output wrEn, output wrData, input flags);
endinterface : flag_if

// ---- src/irq_flags_map.svh ----
// register offsets, bit positions, reset values and sizes of the interrupt flag block
`ifndef IRQ_FLAGS_MAP_SVH
`define IRQ_FLAGS_MAP_SVH

// ****************************************************************
// register offsets (bank 0, low seven address bits)
// ****************************************************************
`define OFF_FLAGS1      7'h00
`define OFF_FLAGS2      7'h01
`define OFF_STATUS      7'h02
`define OFF_MASK        7'h03
`define OFF_STACK_LEVEL 7'h04
`define OFF_COMMON_BASE 7'h70

// ****************************************************************
// flag positions in the two flag registers
// ****************************************************************
`define BIT_TIMER1_ROLLOVER 0
`define BIT_TIMER2_MATCH    1
`define BIT_SERIAL_EVENT    4
`define BIT_SERIAL_COLLIDE  5
`define BIT_ADC_DONE        6
`define BIT_INPUT_LOW       1
`define BIT_OUT_OVERVOLT    4
`define BIT_OUT_OVERCURRENT 5
`define BIT_OUT_UNDERVOLT   7
`define IMPL_FLAGS1         8'h73
`define IMPL_FLAGS2         8'hb2

// ****************************************************************
// sticky status bits of the block's own events
// ****************************************************************
`define ST_IRQ_ENTRY        0
`define ST_STACK_OVERFLOW   1
`define ST_STACK_UNDERFLOW  2
`define ST_FAULT            3
`define IMPL_STATUS         8'h0f

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define RST_FLAGS           8'h00
`define RST_STATUS          8'h00
`define RST_MASK            8'h00
`define STACK_DEPTH         8
`define COMMON_DEPTH        16

`endif

// ---- src/irq_flags_pkg.sv ----
// types shared by the interrupt flag block
package irq_flags_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [8:0]  addr_t;
	typedef logic [12:0] pc_t;
	typedef logic [2:0]  level_t;

	// interrupt sequencing as seen from the core side
	typedef enum logic [2:0] {
		SEQ_IDLE    = 3'b001,
		SEQ_SERVICE = 3'b010,
		SEQ_RESUME  = 3'b100
	} seq_e;
endpackage : irq_flags_pkg

// ---- src/periph_irq_flags.sv ----
// peripheral interrupt flags, request gating, return stack and common memory
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "irq_flags_map.svh"
module periph_irq_flags (
	input  wire logic                 ref_clk,           // system clock, 20 MHz
	input  wire logic                 reset_n,           // asynchronous reset, active low
	input  wire irq_flags_pkg::addr_t busAddr,           // bank in [8:7], offset in [6:0]
	input  wire irq_flags_pkg::byte_t busWrData,         // write data
	input  wire logic                 busWr,             // write strobe
	input  wire logic                 busRd,             // read strobe
	output irq_flags_pkg::byte_t      busRdData,         // read data, cycle after busRd
	input  wire logic                 adcDone,           // conversion complete pulse
	input  wire logic                 serialEvent,       // serial port event pulse
	input  wire logic                 serialCollision,   // serial bus collision pulse
	input  wire logic                 timer2Match,       // timer 2 equals period pulse
	input  wire logic                 timer1Rollover,    // timer 1 roll-over pulse
	input  wire logic                 outUndervolt,      // output undervoltage error pulse
	input  wire logic                 outOvercurrent,    // output overcurrent error pulse
	input  wire logic                 outOvervolt,       // output overvoltage error pulse
	input  wire logic                 inputLow,          // input supply low, level
	input  wire irq_flags_pkg::byte_t periphEnable1,     // enable bits for flags-1
	input  wire irq_flags_pkg::byte_t periphEnable2,     // enable bits for flags-2
	input  wire logic                 globalIrqGate,     // global interrupt gate
	input  wire logic                 peripheralIrqGate, // peripheral interrupt gate
	input  wire logic                 irqTake,           // core takes the interrupt, pulse
	input  wire irq_flags_pkg::pc_t   returnPc,          // return address beside irqTake
	input  wire logic                 irqReturn,         // core leaves the service routine
	output logic                      coreIrqReq,        // interrupt request to the core
	output irq_flags_pkg::pc_t        resumePc,          // popped return address
	output logic                      resumeValid,       // resumePc valid, one cycle
	output logic                      intOut             // block interrupt, level
);
	import irq_flags_pkg::*;

	// ****************************************************************
	// address decode
	// ****************************************************************

	// true for the shared top 16 bytes of any bank
	function automatic logic inCommon(input addr_t a);
		inCommon = (a[6:4] == 3'(`OFF_COMMON_BASE >> 4));
	endfunction : inCommon

	// true for a block register, which lives in bank 0 only
	function automatic logic isReg(input addr_t a, input logic [6:0] off);
		isReg = (a[8:7] == 2'h0) && (a[6:0] == off);
	endfunction : isReg

	// ****************************************************************
	// flag registers
	// ****************************************************************
	flag_if flags1If ();
	flag_if flags2If ();

	// hardware sets, independent of any enable or gate
	assign flags1If.setVec = {
		1'b0,
		adcDone,
		serialCollision,
		serialEvent,
		2'b00,
		timer2Match,
		timer1Rollover
	};
	assign flags2If.setVec = {
		outUndervolt,
		1'b0,
		outOvercurrent,
		outOvervolt,
		2'b00,
		inputLow,
		1'b0
	};

	// software writes, stored as written apart from the fixed zero bits and any flag set in the same cycle
	assign flags1If.wrEn   = busWr && isReg(busAddr, `OFF_FLAGS1);
	assign flags1If.wrData = busWrData;
	assign flags2If.wrEn   = busWr && isReg(busAddr, `OFF_FLAGS2);
	assign flags2If.wrData = busWrData;

	flag_bank #(.IMPL(`IMPL_FLAGS1)) flags1Bank (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.port    (flags1If.bank)
	);

	flag_bank #(.IMPL(`IMPL_FLAGS2)) flags2Bank (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.port    (flags2If.bank)
	);

	// ****************************************************************
	// request gating
	// ****************************************************************
	logic pending;
	seq_e seq_q;
	seq_e seq_d;

	// a source counts only with its own enable and the peripheral gate
	assign pending = peripheralIrqGate &&
		(|(flags1If.flags & periphEnable1) || |(flags2If.flags & periphEnable2));

	// no request while a routine is running, the core keeps one level
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			coreIrqReq <= 1'b0;
		else
			coreIrqReq <= pending && globalIrqGate && (seq_d == SEQ_IDLE);
	end

	// ****************************************************************
	// interrupt sequencing
	// ****************************************************************
	logic push;
	logic pop;

	// a take is honoured only from idle, a return only from service
	assign push = irqTake && (seq_q == SEQ_IDLE);
	assign pop  = irqReturn && (seq_q == SEQ_SERVICE) && !irqTake;

	always_comb
	begin
		seq_d = seq_q;
		unique case (seq_q)
			SEQ_IDLE:
			begin
				if (push)
					seq_d = SEQ_SERVICE;
			end
			SEQ_SERVICE:
			begin
				if (pop)
					seq_d = SEQ_RESUME;
			end
			SEQ_RESUME:
			begin
				seq_d = SEQ_IDLE;
			end
			default:
			begin
				seq_d = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			seq_q <= SEQ_IDLE;
		else
			seq_q <= seq_d;
	end

	// ****************************************************************
	// return address stack
	// ****************************************************************
	level_t     sp_q;
	logic [3:0] depth_q;
	level_t     popAddr;

	// only the program counter is saved, working and status stay with software
	assign popAddr = sp_q - 3'h1;

	word_mem #(.WIDTH(13), .DEPTH(`STACK_DEPTH), .AW(3)) returnStack (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.wrEn    (push),
		.wrAddr  (sp_q),
		.wrData  (returnPc),
		.rdAddr  (popAddr),
		.rdData  (resumePc)
	);

	// pointer wraps like a circular stack, the depth count finds overflow
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sp_q    <= 3'h0;
			depth_q <= 4'h0;
		end
		else if (push)
		begin
			sp_q <= sp_q + 3'h1;
			if (depth_q != 4'(`STACK_DEPTH))
				depth_q <= depth_q + 4'h1;
		end
		else if (pop)
		begin
			sp_q <= popAddr;
			if (depth_q != 4'h0)
				depth_q <= depth_q - 4'h1;
		end
	end

	// resume address comes out of the stack one cycle after the return
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			resumeValid <= 1'b0;
		else
			resumeValid <= pop;
	end

	// ****************************************************************
	// shared memory window
	// ****************************************************************
	byte_t commonRd;

	// bank bits are ignored here so no bank switch is needed
	word_mem #(.WIDTH(8), .DEPTH(`COMMON_DEPTH), .AW(4)) commonMem (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.wrEn    (busWr && inCommon(busAddr)),
		.wrAddr  (busAddr[3:0]),
		.wrData  (busWrData),
		.rdAddr  (busAddr[3:0]),
		.rdData  (commonRd)
	);

	// ****************************************************************
	// block status and interrupt
	// ****************************************************************
	byte_t status_q;
	byte_t mask_q;
	byte_t statusSet;
	logic  faultSet;

	assign faultSet = outUndervolt || outOvercurrent || outOvervolt;

	always_comb
	begin
		statusSet                      = 8'h00;
		statusSet[`ST_IRQ_ENTRY]       = push;
		statusSet[`ST_STACK_OVERFLOW]  = push && (depth_q == 4'(`STACK_DEPTH));
		statusSet[`ST_STACK_UNDERFLOW] = pop && (depth_q == 4'h0);
		statusSet[`ST_FAULT]           = faultSet;
	end

	// write one to clear, a new event in the same cycle wins
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			status_q <= `RST_STATUS;
		else if (busWr && isReg(busAddr, `OFF_STATUS))
			status_q <= ((status_q & ~busWrData) | statusSet) & `IMPL_STATUS;
		else
			status_q <= (status_q | statusSet) & `IMPL_STATUS;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			mask_q <= `RST_MASK;
		else if (busWr && isReg(busAddr, `OFF_MASK))
			mask_q <= busWrData & `IMPL_STATUS;
	end

	// output lags the status by one cycle so it leaves a flop
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			intOut <= 1'b0;
		else
			intOut <= |(status_q & mask_q);
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	byte_t regRd_q;
	logic  selCommon_q;

	// register value captured at the strobe, unmapped addresses read zero
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			regRd_q     <= 8'h00;
			selCommon_q <= 1'b0;
		end
		else
		begin
			selCommon_q <= busRd && inCommon(busAddr);
			regRd_q     <= 8'h00;
			if (busRd)
			begin
				if (isReg(busAddr, `OFF_FLAGS1))
					regRd_q <= flags1If.flags;
				else if (isReg(busAddr, `OFF_FLAGS2))
					regRd_q <= flags2If.flags;
				else if (isReg(busAddr, `OFF_STATUS))
					regRd_q <= status_q;
				else if (isReg(busAddr, `OFF_MASK))
					regRd_q <= mask_q;
				else if (isReg(busAddr, `OFF_STACK_LEVEL))
					regRd_q <= {4'h0, depth_q};
			end
		end
	end

	// the shared memory already registers its own data, so only a select follows
	assign busRdData = selCommon_q ? commonRd : regRd_q;
endmodule : periph_irq_flags

// ---- src/word_mem.sv ----
// small single-port-write memory with registered read data
`timescale 1ns/1ns
module word_mem #(
	parameter int WIDTH = 8,  // word width
	parameter int DEPTH = 16, // number of words
	parameter int AW    = 4   // address width
) (
	input  wire logic             ref_clk, // system clock
	input  wire logic             reset_n, // asynchronous reset, active low
	input  wire logic             wrEn,    // write strobe
	input  wire logic [AW-1:0]    wrAddr,  // write address
	input  wire logic [WIDTH-1:0] wrData,  // write data
	input  wire logic [AW-1:0]    rdAddr,  // read address, sampled every cycle
	output logic      [WIDTH-1:0] rdData   // read data of the previous cycle
);
	logic [WIDTH-1:0] mem [DEPTH];

	// storage has no reset, software must write before it reads
	always_ff @(posedge ref_clk)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
	end

	// read data held in a register
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			rdData <= '0;
		else
			rdData <= mem[rdAddr];
	end
endmodule : word_mem
